// ---- rtl/umlfx_top.sv ----
/*
  Modem-line and FIFO-mode logic of a serial port: 16x baud clock,
  modem status register with change flags, DTR, FIFO sizing and
  automatic RTS. Assumes all inputs are synchronous to I_CLK_SYS
  and that the reference clock is slow enough to be edge sampled.
*/
`timescale 1ns/1ns
`include "umlfx_consts.svh"

module umlfx_top
#(
  parameter int DIV_W = 16
)
(
  // Clock and reset
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_RST,
  // Baud generator
  input  wire logic             i_REF_CLK,
  input  wire logic [DIV_W-1:0] i_DIVISOR,
  output logic                  o_BAUD_CLK_N,
  // Modem lines, active low
  input  wire logic             i_CTS_N,
  input  wire logic             i_DCD_N,
  input  wire logic             i_DSR_N,
  output logic                  o_DTR_N,
  output logic                  o_RTS_N,
  // Status register and interrupt
  input  wire logic             i_STATUS_RD,
  input  wire logic             i_MSI_EN,
  output logic [7:0]            o_MODEM_STATUS,
  output logic                  o_MSI_IRQ,
  // Control bits
  input  wire logic             i_DTR_BIT,
  input  wire logic             i_RTS_BIT,
  input  wire logic             i_LOOP,
  // FIFO configuration
  input  wire logic             i_FIFO_EXTEND,
  input  wire logic             i_FIFO_EXT64,
  input  wire logic             i_FIFO_AUTO_RTS,
  input  wire logic [1:0]       i_RX_TRIG_SEL,
  input  wire logic [6:0]       i_RX_LEVEL,
  output umlfx_pkg::umlfx_mode_t o_FIFO_MODE,
  output logic [6:0]            o_FIFO_DEPTH,
  output logic [6:0]            o_RX_TRIG_LEVEL,
  output logic                  o_AUTO_RTS_ON
);
  import umlfx_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [6:0] trig_of(input logic [1:0] sel,
                                         input logic       ext);
    logic [6:0] t;
    t = `UMLFX_TRIG_STD_0;
    case (sel)
      2'h0:    t = ext ? `UMLFX_TRIG_EXT_0 : `UMLFX_TRIG_STD_0;
      2'h1:    t = ext ? `UMLFX_TRIG_EXT_1 : `UMLFX_TRIG_STD_1;
      2'h2:    t = ext ? `UMLFX_TRIG_EXT_2 : `UMLFX_TRIG_STD_2;
      2'h3:    t = ext ? `UMLFX_TRIG_EXT_3 : `UMLFX_TRIG_STD_3;
      default: t = `UMLFX_TRIG_STD_0;
    endcase
    return t;
  endfunction

  // ****************************************
  // Baud generator
  // ****************************************
  logic             ref_q;
  logic [DIV_W-1:0] baud_cnt;
  logic             baud_n;
  logic             next_ref_q;
  logic [DIV_W-1:0] next_baud_cnt;
  logic             next_baud_n;
  logic             ref_rise;

  assign ref_rise = i_REF_CLK & ~ref_q;

  // Low for one reference period out of every divisor periods
  always_comb
  begin
    next_ref_q    = i_REF_CLK;
    next_baud_cnt = baud_cnt;
    next_baud_n   = baud_n;
    if (i_DIVISOR == '0)
    begin
      // Zero divisor stops the clock rather than dividing by 2^n
      next_baud_cnt = '0;
      next_baud_n   = 1'b1;
    end
    else if (ref_rise)
    begin
      if (baud_cnt >= i_DIVISOR - DIV_W'(1))
      begin
        next_baud_cnt = '0;
        next_baud_n   = 1'b0;
      end
      else
      begin
        next_baud_cnt = baud_cnt + DIV_W'(1);
        next_baud_n   = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      ref_q    <= 1'b0;
      baud_cnt <= '0;
      baud_n   <= 1'b1;
    end
    else
    begin
      ref_q    <= next_ref_q;
      baud_cnt <= next_baud_cnt;
      baud_n   <= next_baud_n;
    end
  end

  assign o_BAUD_CLK_N = baud_n;

  // ****************************************
  // Modem status register
  // ****************************************
  logic [2:0] line;      // {dcd, dsr, cts}, active high
  logic [2:0] line_q;
  logic [2:0] delta;
  logic       primed;
  logic [2:0] next_line_q;
  logic [2:0] next_delta;
  logic       next_primed;
  logic       next_irq;
  logic [2:0] chg;
  logic       irq;

  assign line = {~i_DCD_N, ~i_DSR_N, ~i_CTS_N};
  // First sample after reset only primes, so no false change flags
  assign chg  = primed ? (line ^ line_q) : 3'h0;

  always_comb
  begin
    next_line_q = line;
    next_primed = 1'b1;
    // Set beats clear so a change at the read is not lost
    next_delta  = (delta & ~{3{i_STATUS_RD}}) | chg;
    next_irq    = i_MSI_EN & (|next_delta);
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      // Idle lines read inactive, so status is all zero in reset
      line_q <= 3'h0;
      delta  <= 3'h0;
      primed <= 1'b0;
      irq    <= 1'b0;
    end
    else
    begin
      line_q <= next_line_q;
      delta  <= next_delta;
      primed <= next_primed;
      irq    <= next_irq;
    end
  end

  always_comb
  begin
    o_MODEM_STATUS                    = `UMLFX_STAT_RST;
    o_MODEM_STATUS[`UMLFX_STAT_CTS]   = line_q[0];
    o_MODEM_STATUS[`UMLFX_STAT_DSR]   = line_q[1];
    o_MODEM_STATUS[`UMLFX_STAT_DCD]   = line_q[2];
    o_MODEM_STATUS[`UMLFX_STAT_DCTS]  = delta[0];
    o_MODEM_STATUS[`UMLFX_STAT_DDSR]  = delta[1];
    o_MODEM_STATUS[`UMLFX_STAT_DDCD]  = delta[2];
  end

  assign o_MSI_IRQ = irq;

  // ****************************************
  // Modem control outputs and FIFO mode
  // ****************************************
  logic        dtr_n;
  logic        rts_n;
  logic        auto_rts;
  umlfx_mode_t mode;
  logic [6:0]  depth;
  logic [6:0]  trig;
  logic        next_dtr_n;
  logic        next_rts_n;
  logic        next_auto_rts;
  umlfx_mode_t next_mode;
  logic [6:0]  next_depth;
  logic [6:0]  next_trig;
  logic [6:0]  rts_thr;
  logic        ext;

  always_comb
  begin
    ext           = ~i_FIFO_EXTEND & i_FIFO_EXT64;
    next_mode     = ext ? UMLFX_MODE_EXT : UMLFX_MODE_STD;
    next_depth    = ext ? `UMLFX_DEPTH_EXT : `UMLFX_DEPTH_STD;
    next_trig     = trig_of(i_RX_TRIG_SEL, ext);
    next_auto_rts = ~i_FIFO_EXTEND & i_FIFO_AUTO_RTS;
    rts_thr       = ext ? `UMLFX_RTS_EXT : `UMLFX_RTS_STD;
    next_dtr_n    = ~(i_DTR_BIT & ~i_LOOP);
    // Loop mode keeps the modem lines quiet
    next_rts_n    = ~(i_RTS_BIT & ~i_LOOP);
    if (next_auto_rts && (i_RX_LEVEL >= rts_thr))
    begin
      next_rts_n = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      dtr_n    <= 1'b1;
      rts_n    <= 1'b1;
      auto_rts <= 1'b0;
      mode     <= UMLFX_MODE_STD;
      depth    <= `UMLFX_DEPTH_STD;
      trig     <= `UMLFX_TRIG_STD_0;
    end
    else
    begin
      dtr_n    <= next_dtr_n;
      rts_n    <= next_rts_n;
      auto_rts <= next_auto_rts;
      mode     <= next_mode;
      depth    <= next_depth;
      trig     <= next_trig;
    end
  end

  assign o_DTR_N         = dtr_n;
  assign o_RTS_N         = rts_n;
  assign o_AUTO_RTS_ON   = auto_rts;
  assign o_FIFO_MODE     = mode;
  assign o_FIFO_DEPTH    = depth;
  assign o_RX_TRIG_LEVEL = trig;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  a_baud_low_cause: assert property (
    $fell(o_BAUD_CLK_N) |-> $past(ref_rise) && $past(i_DIVISOR) != '0)
    else $error("baud pulse without reference edge");
  a_baud_div_one: assert property (
    (i_DIVISOR == DIV_W'(1)) && ref_rise |=> !o_BAUD_CLK_N)
    else $error("divide by one missed a pulse");
  a_cts_status: assert property (
    1'b1 |=> o_MODEM_STATUS[`UMLFX_STAT_CTS] == !$past(i_CTS_N))
    else $error("cts status wrong");
  a_dcd_status: assert property (
    1'b1 |=> o_MODEM_STATUS[`UMLFX_STAT_DCD] == !$past(i_DCD_N))
    else $error("dcd status wrong");
  a_dsr_status: assert property (
    1'b1 |=> o_MODEM_STATUS[`UMLFX_STAT_DSR] == !$past(i_DSR_N))
    else $error("dsr status wrong");
  a_dsr_delta: assert property (
    ##1 $changed(i_DSR_N) |=> o_MODEM_STATUS[`UMLFX_STAT_DDSR])
    else $error("dsr change flag missed");
  a_cts_delta: assert property (
    ##1 $changed(i_CTS_N) |=> o_MODEM_STATUS[`UMLFX_STAT_DCTS])
    else $error("cts change flag missed");
  a_dcd_delta: assert property (
    ##1 $changed(i_DCD_N) |=> o_MODEM_STATUS[`UMLFX_STAT_DDCD])
    else $error("dcd change flag missed");
  a_read_clears: assert property (
    i_STATUS_RD && chg == 3'h0 |=> delta == 3'h0)
    else $error("read left a change flag");
  a_irq_on_change: assert property (
    i_MSI_EN && chg != 3'h0 ##1 i_MSI_EN |-> o_MSI_IRQ)
    else $error("modem interrupt missed");
  a_dtr_loop: assert property (
    i_LOOP |=> o_DTR_N)
    else $error("dtr active in loop mode");
  a_dtr_follow: assert property (
    i_DTR_BIT && !i_LOOP |=> !o_DTR_N)
    else $error("dtr not active");
  a_depth_std: assert property (
    i_FIFO_EXTEND |=> o_FIFO_DEPTH == `UMLFX_DEPTH_STD)
    else $error("depth not 16 with extend high");
  a_depth_ext: assert property (
    !i_FIFO_EXTEND && i_FIFO_EXT64 |=> o_FIFO_DEPTH == `UMLFX_DEPTH_EXT)
    else $error("depth not 64");
  a_auto_rts_on: assert property (
    !i_FIFO_EXTEND && i_FIFO_AUTO_RTS |=> o_AUTO_RTS_ON)
    else $error("auto rts not enabled");
  a_rts_drop: assert property (
    !i_FIFO_EXTEND && i_FIFO_AUTO_RTS &&
    i_RX_LEVEL >= (i_FIFO_EXT64 ? `UMLFX_RTS_EXT : `UMLFX_RTS_STD)
    |=> o_RTS_N)
    else $error("rts not dropped at threshold");

  c_baud_pulse:  cover property ($fell(o_BAUD_CLK_N));
  c_read_change: cover property (i_STATUS_RD && chg != 3'h0);
  c_irq:         cover property ($rose(o_MSI_IRQ));
  c_rts_drop:    cover property (o_AUTO_RTS_ON && $rose(o_RTS_N));
endmodule

// ---- rtl/umlfx_consts.svh ----
/*
  Constants of the modem-line and FIFO-mode block: status bit
  positions, reset values, FIFO depths and trigger levels.
  Assumes it is included by bare name from the top module file.
*/
`ifndef UMLFX_CONSTS_SVH
`define UMLFX_CONSTS_SVH

// ****************************************
// Modem status register layout
// ****************************************
`define UMLFX_STAT_DCTS    0
`define UMLFX_STAT_DDSR    1
`define UMLFX_STAT_DDCD    3
`define UMLFX_STAT_CTS     4
`define UMLFX_STAT_DSR     5
`define UMLFX_STAT_DCD     7
`define UMLFX_STAT_RST     8'h00

// ****************************************
// FIFO sizing and receive thresholds
// ****************************************
`define UMLFX_DEPTH_STD    7'h10
`define UMLFX_DEPTH_EXT    7'h40
`define UMLFX_RTS_STD      7'h0e
`define UMLFX_RTS_EXT      7'h38
`define UMLFX_TRIG_STD_0   7'h01
`define UMLFX_TRIG_STD_1   7'h04
`define UMLFX_TRIG_STD_2   7'h08
`define UMLFX_TRIG_STD_3   7'h0e
`define UMLFX_TRIG_EXT_0   7'h01
`define UMLFX_TRIG_EXT_1   7'h10
`define UMLFX_TRIG_EXT_2   7'h20
`define UMLFX_TRIG_EXT_3   7'h38

`endif

// ---- rtl/umlfx_pkg.sv ----
/*
  Types of the modem-line and FIFO-mode block.
  Assumes the constants header sits beside it in rtl/.
*/
package umlfx_pkg;
  // FIFO operating mode, one-hot
  typedef enum logic [1:0]
  {
    UMLFX_MODE_STD = 2'b01,
    UMLFX_MODE_EXT = 2'b10
  } umlfx_mode_t;
endpackage

// ---- verif/umlfx_modem.sv ----
/*
  Behavioural modem on the far side of the modem lines.
  Assumes the bench asks for one set of line levels at a time.
*/
`timescale 1ns/1ns
module umlfx_modem
(
  // Clock
  input  wire logic       i_clk,
  // Requests from the bench: {dcd, dsr, cts}, active low
  input  wire logic [2:0] i_lines_n,
  input  wire logic       i_slow,
  // Lines towards the port
  output logic            o_cts_n,
  output logic            o_dsr_n,
  output logic            o_dcd_n,
  // Lines from the port, watched only
  input  wire logic       i_dtr_n,
  input  wire logic       i_rts_n
);
  logic [2:0] stage [0:2];
  logic [2:0] lines_n;

  initial
  begin
    stage[0] = 3'h7;
    stage[1] = 3'h7;
    stage[2] = 3'h7;
  end

  // Slow answer lags three cycles, like a sluggish data set
  always @(posedge i_clk)
  begin
    stage[0] <= i_lines_n;
    stage[1] <= stage[0];
    stage[2] <= stage[1];
  end

  assign lines_n = i_slow ? stage[2] : stage[0];
  assign o_cts_n = lines_n[0];
  assign o_dsr_n = lines_n[1];
  assign o_dcd_n = lines_n[2];
endmodule

// ---- verif/tb_top.sv ----
/*
  Self-checking bench for the modem-line and FIFO-mode block.
  Assumes the modem model is compiled before this file.
*/
`timescale 1ns/1ns
module tb_top;
  import umlfx_pkg::*;
  logic        clk, rst, ref_clk, rd, msi_en, dtr_bit, rts_bit, lp;
  logic        ext, e64, auto_en, slow, baud_n, dtr_n, rts_n, irq;
  logic [15:0] divisor;
  logic [2:0]  req, cur, nxt;
  wire  [2:0]  cts_dsr_dcd;
  logic [1:0]  sel;
  logic [6:0]  lvl, depth, trig, thr;
  logic [7:0]  stat;
  logic        auto_on;
  umlfx_mode_t mode;
  logic [7:0]  exp_q [$];
  int          err_count, total_checks, cyc;

  umlfx_modem i_modem (.i_clk(clk), .i_lines_n(req), .i_slow(slow),
    .o_cts_n(cts_dsr_dcd[0]), .o_dsr_n(cts_dsr_dcd[1]),
    .o_dcd_n(cts_dsr_dcd[2]), .i_dtr_n(dtr_n), .i_rts_n(rts_n));

  umlfx_top #(.DIV_W(16)) i_dut (.I_CLK_SYS(clk), .I_RST(rst),
    .i_REF_CLK(ref_clk), .i_DIVISOR(divisor), .o_BAUD_CLK_N(baud_n),
    .i_CTS_N(cts_dsr_dcd[0]), .i_DCD_N(cts_dsr_dcd[2]),
    .i_DSR_N(cts_dsr_dcd[1]), .o_DTR_N(dtr_n), .o_RTS_N(rts_n),
    .i_STATUS_RD(rd), .i_MSI_EN(msi_en), .o_MODEM_STATUS(stat),
    .o_MSI_IRQ(irq),
    .i_DTR_BIT(dtr_bit), .i_RTS_BIT(rts_bit), .i_LOOP(lp),
    .i_FIFO_EXTEND(ext), .i_FIFO_EXT64(e64), .i_FIFO_AUTO_RTS(auto_en),
    .i_RX_TRIG_SEL(sel), .i_RX_LEVEL(lvl), .o_FIFO_MODE(mode),
    .o_FIFO_DEPTH(depth), .o_RX_TRIG_LEVEL(trig),
    .o_AUTO_RTS_ON(auto_on));

  // ****************************************
  // Clocks, helpers, scoreboard
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Reference clock at a quarter of the system rate
  initial
  begin
    ref_clk = 1'b0;
    forever
    begin
      repeat (2) @(posedge clk);
      #1 ref_clk = ~ref_clk;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [7:0] stat_of(input logic [2:0] l, d);
    stat_of = {~l[2], 1'b0, ~l[1], ~l[0], d[2], 1'b0, d[1], d[0]};
  endfunction

  // Status value seen on each read edge against the oldest note
  always @(posedge clk)
    if (rd === 1'b1)
      chk(stat, exp_q.pop_front());

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (baud_n !== v && n < 400)
    begin
      step(1);
      n++;
    end
  endtask

  // Low width one reference period, fall to fall divisor periods
  task automatic baud_chk(input int d);
    int lo, per;
    divisor = 16'(d);
    repeat (2)
    begin
      wait_lvl(1'b1);
      wait_lvl(1'b0);
    end
    lo = 0;
    while (baud_n === 1'b0 && lo < 400)
    begin
      step(1);
      lo++;
    end
    per = lo;
    while (baud_n !== 1'b0 && per < 400)
    begin
      step(1);
      per++;
    end
    chk(8'(lo), 8'd4);
    chk(8'(per), 8'(4 * d));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst, rd, msi_en, rts_bit, lp, ext, e64, auto_en, slow} = 9'h101;
    {divisor, sel, lvl, dtr_bit, req, cur} = '0;
    req = 3'h7;
    cur = 3'h7;
    dtr_bit = 1'b1;
    void'($urandom(32'hf633));
    step(8);
    chk(stat, 8'h00);
    chk(dtr_n, 1'b1);
    chk(baud_n, 1'b1);
    rst = 1'b0;
    step(2);
    for (int k = 0; k < 12; k++)
    begin
      nxt = 3'($urandom);
      req = nxt;
      slow = k[0];
      msi_en = k[1];
      step(8);
      chk(irq, msi_en & |(nxt ^ cur));
      exp_q.push_back(stat_of(nxt, nxt ^ cur));
      exp_q.push_back(stat_of(nxt, 3'h0));
      rd = 1'b1;
      step(2);
      rd = 1'b0;
      chk(irq, 1'b0);
      cur = nxt;
    end
    for (int i = 0; i < 4; i++)
    begin
      {lp, dtr_bit} = 2'(i);
      step(2);
      chk(dtr_n, !(dtr_bit && !lp));
    end
    lp = 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      {sel, auto_en, e64, ext} = 5'(i);
      rts_bit = 1'($urandom);
      thr = (!ext && e64) ? 7'h38 : 7'h0e;
      lvl = i[5] ? thr : thr - 7'h01;
      step(2);
      chk(mode, (!ext && e64) ? UMLFX_MODE_EXT : UMLFX_MODE_STD);
      chk(depth, (!ext && e64) ? 7'h40 : 7'h10);
      chk(trig, (!ext && e64) ? 7'(16 * sel + (sel == 0) + 8 * (sel == 3))
                              : (sel == 0 ? 7'h01 : 7'(2 ** (sel + 1)) -
                                 7'(2 * (sel == 3))));
      chk(auto_on, !ext && auto_en);
      chk(rts_n, !rts_bit | (!ext && auto_en && i[5]));
    end
    baud_chk(2);
    baud_chk(3);
    baud_chk(5);
    // Divide by one holds the baud output low
    divisor = 16'h0001;
    step(8);
    chk(baud_n, 1'b0);
    divisor = 16'h0000;
    step(8);
    repeat (40)
    begin
      step(1);
      chk(baud_n, 1'b1);
    end
    wrap_up();
  end
endmodule
